// ==== pin_driver.sv ====
// pin_driver: far-side model of the two timer input pins
// assumes: pclk domain; pins idle low, one high pulse per request
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
  parameter int HIGH_CYCLES = 4
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requests from the bench
  input  wire logic [1:0] pulse_req,
  // pins
  output logic            timer_input_a,
  output logic            timer_input_b
);
  logic [7:0] cnt_r [2];

  // each pin rises on request and falls after HIGH_CYCLES
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r[i] <= 8'h00;
      end else if (pulse_req[i]) begin
        cnt_r[i] <= 8'(HIGH_CYCLES);
      end else if (cnt_r[i] != 8'h00) begin
        cnt_r[i] <= cnt_r[i] - 8'h01;
      end
    end
  end

  assign timer_input_a = (cnt_r[0] != 8'h00);
  assign timer_input_b = (cnt_r[1] != 8'h00);
endmodule // pin_driver
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for the timer pin i/o control block
// assumes: tpio_pkg, tpio_control and pin_driver compiled first
`timescale 1ns/1ps
`default_nettype none
module tb
  import tpio_pkg::*;
;
  typedef struct packed {
    logic [7:0]    ctrl;
    timer_events_t e;
    logic          lvl;
  } orow_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] trg;
    logic [7:0] clk;
  } irow_t;

  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  timer_events_t     ev;
  logic              prescale_tick, ext_clock_up, ext_clock_down, trigger_a, trigger_b;
  logic              gate_level, count_up, on_chip_event;
  logic              timer_input_a, timer_input_b, timer_output_a, timer_output_b;
  logic [1:0]        pulse_req;
  logic [7:0]        ri;
  int                err_count, comparisons, n_tick, n_trig, n_clk, n_dn, n_trb, cycles;

  orow_t orows [9] = '{'{8'h3C, 4'h8, 1'b1}, '{8'h7D, 4'h8, 1'b0}, '{8'hBD, 4'h8, 1'b0},
                       '{8'hFC, 4'h8, 1'b0}, '{8'hFD, 4'h8, 1'b1}, '{8'hDD, 4'h4, 1'b0},
                       '{8'hF9, 4'h2, 1'b0}, '{8'hF0, 4'h2, 1'b1}, '{8'h9C, 4'hC, 1'b1}};
  irow_t irows [8] = '{'{8'h78, 8'h01, 8'h00}, '{8'h74, 8'h01, 8'h00}, '{8'h7C, 8'h02, 8'h00},
                       '{8'h70, 8'h00, 8'h00}, '{8'h8C, 8'h00, 8'h02}, '{8'hA8, 8'h01, 8'h00},
                       '{8'h0C, 8'h00, 8'h00}, '{8'hCC, 8'h00, 8'hFF}};

  tpio_control #(.PRESCALE_W(8)) i_tpio_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ev, .prescale_tick, .ext_clock_up, .ext_clock_down,
    .trigger_a, .trigger_b, .gate_level, .count_up, .timer_input_a, .timer_input_b,
    .timer_output_a, .timer_output_b, .on_chip_event);
  pin_driver #(.HIGH_CYCLES(4)) i_pin_driver (.pclk, .presetn, .pulse_req, .timer_input_a,
    .timer_input_b);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----
  // pulse counters and timeout
  // ----
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (prescale_tick === 1'b1) n_tick <= n_tick + 1;
    if (trigger_a === 1'b1) n_trig <= n_trig + 1;
    if (ext_clock_up === 1'b1) n_clk <= n_clk + 1;
    if (ext_clock_down === 1'b1) n_dn <= n_dn + 1;
    if (trigger_b === 1'b1) n_trb <= n_trb + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(0, 1, "no ready");
  endtask

  task automatic fire(input timer_events_t e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
    #1;
  endtask

  task automatic pin_pulse(input logic [7:0] c, input logic [1:0] req);
    apb(1'b1, IDX_INPUT_PIN_CONTROL, c);
    #1;
    n_trig = 0;
    n_clk = 0;
    n_dn = 0;
    n_trb = 0;
    @(posedge pclk);
    pulse_req <= req;
    @(posedge pclk);
    pulse_req <= 2'b00;
    repeat (16) @(posedge pclk);
    #1;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    ev = '0; pulse_req = '0; err_count = 0; comparisons = 0; cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(timer_output_a, 1, "out a dis");
    chk(timer_output_b, 1, "out b dis");
    n_tick = 0;
    repeat (10) @(posedge pclk);
    #1;
    chk(n_tick, 10, "div 1");
    for (int a = 8'hFA; a <= 8'hFE; a++) begin
      apb(1'b0, 8'(a), 8'h00);
      chk(rd, 0, "reset val");
    end
    apb(1'b0, 8'hFF, 8'h00);
    chk(er, 1, "unmapped err");
    chk(rd, 0, "unmapped rd");
    apb(1'b1, IDX_PRESCALER_PRESET, 8'h03);
    fire(4'h1);
    n_tick = 0;
    repeat (40) @(posedge pclk);
    #1;
    chk(n_tick, 10, "div 4");
    apb(1'b1, IDX_TIMER_MODE, 8'hC0);
    foreach (orows[i]) for (int o = 0; o < 2; o++) begin
      ri = o ? IDX_OUTPUT_B_CONTROL : IDX_OUTPUT_A_CONTROL;
      apb(1'b1, ri, orows[i].ctrl);
      fire(orows[i].e);
      chk(o ? timer_output_b : timer_output_a, orows[i].lvl, "pin");
      apb(1'b0, ri, 8'h00);
      chk(rd[0], orows[i].lvl, "level read");
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, IDX_OUTPUT_A_CONTROL, k[0] ? 8'hFE : 8'hFC);
      apb(1'b1, IDX_OUTPUT_B_CONTROL, k[0] ? 8'hFC : 8'hFE);
      fire(k[1] ? 4'h2 : 4'h8);
      chk(on_chip_event, k[0] ^ k[1], "pulse");
      @(posedge pclk);
      #1;
      chk(on_chip_event, 0, "pulse end");
    end
    chk(timer_output_a, 0, "out a en");
    apb(1'b1, IDX_TIMER_MODE, 8'h00);
    #1;
    chk(timer_output_a, 1, "out a off");
    chk(timer_output_b, 1, "out b off");
    apb(1'b1, IDX_TIMER_EVENT_FLAGS, 8'h00);
    fire(4'h8);
    apb(1'b0, IDX_TIMER_EVENT_FLAGS, 8'h00);
    chk(rd[FLAG_COMPARE0], 1, "flag set");
    apb(1'b1, IDX_TIMER_EVENT_FLAGS, 8'h00);
    apb(1'b0, IDX_TIMER_EVENT_FLAGS, 8'h00);
    chk(rd[FLAG_COMPARE0], 0, "flag clr");
    foreach (irows[i]) begin
      pin_pulse(irows[i].ctrl, 2'b01);
      chk(n_trig, irows[i].trg, "trigger");
      if (irows[i].clk != 8'hFF) chk(n_clk, irows[i].clk, "ext clk");
    end
    pin_pulse(8'h83, 2'b10);
    chk(n_dn, 2, "clk down");
    chk(n_clk, 0, "clk up idle");
    pin_pulse(8'h12, 2'b10);
    chk(n_trb, 1, "trigger b");
    apb(1'b1, IDX_INPUT_PIN_CONTROL, 8'h20);
    #1;
    chk(gate_level, 0, "gate");
    apb(1'b1, IDX_INPUT_PIN_CONTROL, 8'hB0);
    #1;
    chk(count_up, 0, "direction");
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ==== tpio_control.sv ====
// timer pin i/o control: input pin roles and edges, prescaler, output pins, flags
// assumes: apb master on pclk; counter core supplies event pulses and reload
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - input function code assigns both pin roles
// - two-bit edge select per input pin
// - new preset loaded at underflow or reload
// - prescaler starts at zero, divides by one
// - prescaler divides by preset plus one
// - fastest tick is oscillator over six
// - compare-0 action drives output a
// - compare-1 action drives each output
// - wrap action drives output a
// - output b has own action fields
// - simultaneous events AND their action codes
// - compare-0 pulse enable makes one-cycle pulse
// - wrap pulse enable makes one-cycle pulse
// - software writes set preset pin level
// - preset bit reads live pin level
// - disabled output forced high
// - clock control low: input function picks clock
// - compare-0 flag set by hardware, software clears
module tpio_control
  import tpio_pkg::*;
#(
  parameter int PRESCALE_W = 8
) (
  // apb
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // counter core
  input  wire timer_events_t       ev,
  output logic                     prescale_tick,
  output logic                     ext_clock_up,
  output logic                     ext_clock_down,
  output logic                     trigger_a,
  output logic                     trigger_b,
  output logic                     gate_level,
  output logic                     count_up,
  // pins
  input  wire logic                timer_input_a,
  input  wire logic                timer_input_b,
  output logic                     timer_output_a,
  output logic                     timer_output_b,
  output logic                     on_chip_event
);

  if (PRESCALE_W != 8) begin : g_bad_width
    $error("prescaler width must be 8");
  end

  input_ctrl_t             in_ctrl_r;
  logic [PRESCALE_W-1:0]   preset_r;
  output_ctrl_t            oa_ctrl_r;
  output_ctrl_t            ob_ctrl_r;
  logic [7:0]              flags_r;
  logic [7:0]              mode_r;
  logic [PRESCALE_W-1:0]   pre_cnt_r;
  logic                    pulse_r;
  logic [1:0]              sync_a_r;
  logic [1:0]              sync_b_r;
  logic                    prev_a_r;
  logic                    prev_b_r;
  logic                    edge_a;
  logic                    edge_b;
  logic                    lvl_a;
  logic                    lvl_b;
  logic                    wr;
  logic                    rd;
  logic [7:0]              idx;
  logic                    mapped;
  logic                    wr_oa;
  logic                    wr_ob;
  logic                    src_tick;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign idx    = paddr[9:2];
  assign mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) &&
                  (idx == IDX_INPUT_PIN_CONTROL || idx == IDX_PRESCALER_PRESET ||
                   idx == IDX_OUTPUT_A_CONTROL || idx == IDX_OUTPUT_B_CONTROL ||
                   idx == IDX_TIMER_EVENT_FLAGS || idx == IDX_TIMER_MODE);
  assign wr      = psel && penable && pwrite && mapped;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_oa   = wr && idx == IDX_OUTPUT_A_CONTROL;
  assign wr_ob   = wr && idx == IDX_OUTPUT_B_CONTROL;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ctrl_r <= input_ctrl_t'(RESET_BYTE);
      preset_r  <= RESET_BYTE;
      oa_ctrl_r <= output_ctrl_t'(RESET_BYTE);
      ob_ctrl_r <= output_ctrl_t'(RESET_BYTE);
      mode_r    <= RESET_BYTE;
    end else if (wr) begin
      case (idx)
        IDX_INPUT_PIN_CONTROL: in_ctrl_r <= input_ctrl_t'(pwdata[7:0]);
        IDX_PRESCALER_PRESET:  preset_r  <= pwdata[7:0];
        IDX_OUTPUT_A_CONTROL:  oa_ctrl_r <= output_ctrl_t'(pwdata[7:0]);
        IDX_OUTPUT_B_CONTROL:  ob_ctrl_r <= output_ctrl_t'(pwdata[7:0]);
        IDX_TIMER_MODE:        mode_r    <= pwdata[7:0];
        default:               mode_r    <= mode_r;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // flags: hardware set wins over software clear
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= RESET_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr && idx == IDX_TIMER_EVENT_FLAGS) begin
          flags_r[i] <= pwdata[i];
        end
      end
      if (ev.compare0) begin
        flags_r[FLAG_COMPARE0] <= 1'b1;
        if (flags_r[FLAG_COMPARE0]) begin
          flags_r[FLAG_OVR_CMP0] <= 1'b1;
        end
      end
      if (ev.compare1) begin
        flags_r[FLAG_COMPARE1] <= 1'b1;
      end
      if (ev.wrap) begin
        flags_r[FLAG_WRAP] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    if (rd && mapped) begin
      case (idx)
        IDX_INPUT_PIN_CONTROL: b = in_ctrl_r;
        IDX_PRESCALER_PRESET:  b = preset_r;
        IDX_OUTPUT_A_CONTROL:  b = {oa_ctrl_r[7:1], lvl_a};
        IDX_OUTPUT_B_CONTROL:  b = {ob_ctrl_r[7:1], lvl_b};
        IDX_TIMER_EVENT_FLAGS: b = flags_r;
        IDX_TIMER_MODE:        b = mode_r;
        default:               b = 8'h00;
      endcase
    end
    prdata = {24'h000000, b};
  end

  // ------------------------------------------------------------------
  // input synchronisers and edge detect
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_r <= 2'b00;
      sync_b_r <= 2'b00;
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
    end else begin
      sync_a_r <= {sync_a_r[0], timer_input_a};
      sync_b_r <= {sync_b_r[0], timer_input_b};
      prev_a_r <= sync_a_r[1];
      prev_b_r <= sync_b_r[1];
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    case (sel)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_FALL: edge_hit = was && !now;
      EDGE_RISE: edge_hit = !was && now;
      EDGE_BOTH: edge_hit = was != now;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // one event per pin per cycle: a single comparison of two stable samples
  assign edge_a = edge_hit({in_ctrl_r.first_pin_edge_hi, in_ctrl_r.first_pin_edge_lo},
                           sync_a_r[1], prev_a_r);
  assign edge_b = edge_hit({in_ctrl_r.second_pin_edge_hi, in_ctrl_r.second_pin_edge_lo},
                           sync_b_r[1], prev_b_r);

  // ------------------------------------------------------------------
  // input pin role decode
  // ------------------------------------------------------------------
  always_comb begin
    ext_clock_up   = 1'b0;
    ext_clock_down = 1'b0;
    trigger_a      = 1'b0;
    trigger_b      = 1'b0;
    gate_level     = 1'b1;
    count_up       = 1'b1;
    case (in_ctrl_r.input_function)
      INFN_UNUSED: ;
      4'h1: trigger_b = edge_b;
      4'h2: gate_level = sync_a_r[1];
      4'h3: begin
        gate_level = sync_a_r[1];
        trigger_b  = edge_b;
      end
      4'h4: ext_clock_up = edge_b;
      4'h5: trigger_a = edge_a;
      4'h6: begin
        gate_level   = sync_a_r[1];
        ext_clock_up = edge_b;
      end
      4'h7: begin
        trigger_a = edge_a;
        trigger_b = edge_b;
      end
      INFN_UPDN_CLK: begin
        ext_clock_up   = edge_a;
        ext_clock_down = edge_b;
      end
      4'h9: begin
        count_up     = sync_a_r[1];
        ext_clock_up = edge_b;
      end
      INFN_UPDN_TRIG: begin
        trigger_a = edge_a;
        trigger_b = edge_b;
        count_up  = !edge_b;
      end
      4'hB: count_up = sync_a_r[1];
      INFN_AUTODISC: begin
        // quadrature: direction from phase of b at a edge
        ext_clock_up   = edge_a && (sync_a_r[1] != sync_b_r[1]);
        ext_clock_down = edge_a && (sync_a_r[1] == sync_b_r[1]);
      end
      4'hD: begin
        trigger_a    = edge_a;
        ext_clock_up = edge_b;
      end
      4'hE: begin
        ext_clock_up = edge_a;
        trigger_b    = edge_b;
      end
      4'hF: begin
        trigger_a  = edge_a;
        gate_level = sync_b_r[1];
      end
      default: ;
    endcase
  end

  // ------------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------------
  // with clock control low, external clock functions feed the prescaler, else the internal clock
  assign src_tick = mode_r[MODE_CLK_CTRL] ? 1'b1 :
                    ((in_ctrl_r.input_function inside {4'h4, 4'h6, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE}) ?
                     (ext_clock_up || ext_clock_down) : 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= '0;
    end else if (ev.reload) begin
      pre_cnt_r <= preset_r;
    end else if (src_tick) begin
      if (pre_cnt_r == '0) begin
        pre_cnt_r <= preset_r;
      end else begin
        pre_cnt_r <= pre_cnt_r - 1'b1;
      end
    end
  end

  // pclk here stands for the oscillator over six tick source
  assign prescale_tick = src_tick && (pre_cnt_r == '0) && !ev.reload;

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  tpio_output_pin u_out_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .ctrl     (oa_ctrl_r),
    .enable   (mode_r[MODE_FIRST_OE]),
    .sw_write (wr_oa),
    .sw_level (pwdata[0]),
    .ev       (ev),
    .level    (lvl_a),
    .pin      (timer_output_a)
  );

  tpio_output_pin u_out_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .ctrl     (ob_ctrl_r),
    .enable   (mode_r[MODE_SECOND_OE]),
    .sw_write (wr_ob),
    .sw_level (pwdata[0]),
    .ev       (ev),
    .level    (lvl_b),
    .pin      (timer_output_b)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= (ev.compare0 && oa_ctrl_r.pulse_enable) ||
                 (ev.wrap && ob_ctrl_r.pulse_enable);
    end
  end
  assign on_chip_event = pulse_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_cmp0_pulse;
    @(posedge pclk) disable iff (!presetn)
      (ev.compare0 && oa_ctrl_r.pulse_enable) |=> on_chip_event;
  endproperty
  a_cmp0_pulse: assert property (p_cmp0_pulse) else $error("no pulse after compare 0");

  property p_wrap_pulse;
    @(posedge pclk) disable iff (!presetn)
      (ev.wrap && ob_ctrl_r.pulse_enable) |=> on_chip_event;
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("no pulse after wrap");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      ev.compare0 |=> flags_r[FLAG_COMPARE0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("compare 0 flag not set");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      ev.reload |=> (pre_cnt_r == $past(preset_r));
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");

  property p_hold_preset;
    @(posedge pclk) disable iff (!presetn)
      (!ev.reload && src_tick && pre_cnt_r != '0) |=> (pre_cnt_r == $past(pre_cnt_r) - 1'b1);
  endproperty
  a_hold_preset: assert property (p_hold_preset) else $error("preset taken early");

  property p_disabled_a;
    @(posedge pclk) disable iff (!presetn)
      !mode_r[MODE_FIRST_OE] |-> timer_output_a;
  endproperty
  a_disabled_a: assert property (p_disabled_a) else $error("output a not high");

  property p_rise_edge;
    @(posedge pclk) disable iff (!presetn)
      (in_ctrl_r.first_pin_edge_hi && !in_ctrl_r.first_pin_edge_lo) |->
        (edge_a == (sync_a_r[1] && !$past(sync_a_r[1])));
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge detect wrong");

  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      ##3 (prev_a_r == $past(timer_input_a, 3));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("input sync delay wrong");

endmodule // tpio_control
`default_nettype wire

// ==== tpio_output_pin.sv ====
// one timer output pin: merges simultaneous event actions and drives the pin
// assumes: events are single-cycle pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module tpio_output_pin
  import tpio_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // control
  input  wire output_ctrl_t  ctrl,
  input  wire logic          enable,
  input  wire logic          sw_write,
  input  wire logic          sw_level,
  input  wire timer_events_t ev,
  // pin
  output logic               level,
  output logic               pin
);

  pin_action_t act;
  logic        any_ev;
  logic        level_r;
  logic        level_nxt;

  // ------------------------------------------------------------------
  // action merge
  // ------------------------------------------------------------------
  always_comb begin
    logic [1:0] code;
    code   = 2'b11;
    any_ev = 1'b0;
    if (ev.compare0) begin
      code   = code & ctrl.compare0_pin_action;
      any_ev = 1'b1;
    end
    if (ev.compare1) begin
      code   = code & ctrl.compare1_pin_action;
      any_ev = 1'b1;
    end
    if (ev.wrap) begin
      code   = code & ctrl.wrap_pin_action;
      any_ev = 1'b1;
    end
    act = pin_action_t'(code);
  end

  always_comb begin
    level_nxt = level_r;
    if (any_ev) begin
      case (act)
        ACT_SET:    level_nxt = 1'b1;
        ACT_TOGGLE: level_nxt = ~level_r;
        ACT_RESET:  level_nxt = 1'b0;
        ACT_NOP:    level_nxt = level_r;
        default:    level_nxt = level_r;
      endcase
    end else if (sw_write) begin
      level_nxt = sw_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
  assign pin   = enable ? level_r : 1'b1;

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
      (any_ev && act == ACT_TOGGLE) |=> (level_r != $past(level_r));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert level");

  property p_disabled_high;
    @(posedge pclk) disable iff (!presetn)
      !enable |-> pin;
  endproperty
  a_disabled_high: assert property (p_disabled_high) else $error("disabled pin not high");

endmodule // tpio_output_pin
`default_nettype wire

// ==== tpio_pkg.sv ====
// package: register map, field positions and codes for the timer pin i/o control block
// assumes: apb register bus, 32-bit data, one register per aligned word
package tpio_pkg;

  // register indices (printed offsets are not word aligned: byte address = 4 * index)
  localparam logic [7:0] IDX_INPUT_PIN_CONTROL = 8'hFA;
  localparam logic [7:0] IDX_PRESCALER_PRESET  = 8'hFB;
  localparam logic [7:0] IDX_OUTPUT_A_CONTROL  = 8'hFC;
  localparam logic [7:0] IDX_OUTPUT_B_CONTROL  = 8'hFD;
  localparam logic [7:0] IDX_TIMER_EVENT_FLAGS = 8'hFE;
  localparam logic [7:0] IDX_TIMER_MODE        = 8'hF9;
  localparam int         ADDR_W                = 12;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // timer_event_flags bit positions
  localparam int FLAG_CAPTURE0  = 7;
  localparam int FLAG_CAPTURE1  = 6;
  localparam int FLAG_COMPARE0  = 5;
  localparam int FLAG_COMPARE1  = 4;
  localparam int FLAG_WRAP      = 3;
  localparam int FLAG_OVR_CAP0  = 2;
  localparam int FLAG_OVR_CMP0  = 1;
  localparam int FLAG_CAP_AND   = 0;

  // timer mode bit positions
  localparam int MODE_SECOND_OE = 7;
  localparam int MODE_FIRST_OE  = 6;
  localparam int MODE_CLK_CTRL  = 2;

  // oscillator cycles per counter clock with halving selected
  localparam int OSC_PER_TICK = 6;

  // output pin action codes
  typedef enum logic [1:0] {
    ACT_SET    = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_RESET  = 2'b10,
    ACT_NOP    = 2'b11
  } pin_action_t;

  // edge selection codes
  localparam logic [1:0] EDGE_NONE = 2'b00;
  localparam logic [1:0] EDGE_FALL = 2'b01;
  localparam logic [1:0] EDGE_RISE = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  // input function codes named in the behaviour list
  localparam logic [3:0] INFN_UNUSED    = 4'h0;
  localparam logic [3:0] INFN_UPDN_CLK  = 4'h8;
  localparam logic [3:0] INFN_UPDN_TRIG = 4'hA;
  localparam logic [3:0] INFN_AUTODISC  = 4'hC;

  typedef struct packed {
    logic [3:0] input_function;
    logic       first_pin_edge_hi;
    logic       first_pin_edge_lo;
    logic       second_pin_edge_hi;
    logic       second_pin_edge_lo;
  } input_ctrl_t;

  typedef struct packed {
    pin_action_t compare0_pin_action;
    pin_action_t compare1_pin_action;
    pin_action_t wrap_pin_action;
    logic        pulse_enable;
    logic        pin_preset_level;
  } output_ctrl_t;

  // counter core events arriving at the block
  typedef struct packed {
    logic compare0;
    logic compare1;
    logic wrap;
    logic reload;
  } timer_events_t;

endpackage
